// ==== rpu_pkg.sv ====
// package: register map, field layout and constants of the remote pulse unit
package rpu_pkg;
    localparam logic [15:0] RPU_OFS_CONFIG  = 16'h5340;
    localparam logic [15:0] RPU_OFS_CARRIER = 16'h5342;
    localparam logic [15:0] RPU_OFS_LENGTH  = 16'h5344;
    localparam logic [15:0] RPU_OFS_INT     = 16'h5346;
    localparam int          RPU_CGSEL_MSB   = 15;
    localparam int          RPU_CGSEL_LSB   = 12;
    localparam int          RPU_LCSEL_MSB   = 11;
    localparam int          RPU_LCSEL_LSB   = 8;
    localparam int          RPU_DIR_BIT     = 1;
    localparam int          RPU_EN_BIT      = 0;
    localparam int          RPU_CL_MSB      = 13;
    localparam int          RPU_CL_LSB      = 8;
    localparam int          RPU_CH_MSB      = 5;
    localparam int          RPU_CH_LSB      = 0;
    localparam int          RPU_LEN_MSB     = 15;
    localparam int          RPU_LEN_LSB     = 8;
    localparam int          RPU_DT_BIT      = 0;
    localparam int          RPU_FLAG_LSB    = 8;
    localparam int          RPU_IE_LSB      = 0;
    localparam logic [3:0]  RPU_SEL_RESVD   = 4'hF;
    localparam logic [3:0]  RPU_SEL_RESET   = 4'h0;
    localparam logic [5:0]  RPU_CARR_RESET  = 6'h00;
    localparam logic [7:0]  RPU_LEN_RESET   = 8'h00;
    localparam logic [7:0]  RPU_LEN_ZERO    = 8'h00;
    localparam logic [7:0]  RPU_LEN_ONE     = 8'h01;
    localparam logic [5:0]  RPU_CNT_ONE     = 6'h01;
    localparam int          RPU_DIV_W       = 14;
    localparam logic [13:0] RPU_DIV_ONE     = 14'h0001;
    localparam logic [2:0]  RPU_CAUSE_NONE  = 3'h0;
    localparam int          RPU_UF          = 0;
    localparam int          RPU_RE          = 1;
    localparam int          RPU_FE          = 2;
    localparam logic [15:0] RPU_RD_ZERO     = 16'h0000;
    typedef enum logic [1:0] {
        RPU_CARR_HIGH = 2'b01,
        RPU_CARR_LOW  = 2'b10
    } rpu_carr_state_t;
endpackage : rpu_pkg

// ==== rpu_tick_if.sv ====
// interface: divider selections and tick enables between top and divider
`timescale 1ns/1ps
interface rpu_tick_if;
    logic       run;
    logic [3:0] cg_sel;
    logic [3:0] lc_sel;
    logic       cg_tick;
    logic       lc_tick;
    modport ctrl (output run, output cg_sel, output lc_sel, input cg_tick, input lc_tick);
    modport div  (input run, input cg_sel, input lc_sel, output cg_tick, output lc_tick);
endinterface : rpu_tick_if

// ==== rpu_divider.sv ====
// power-of-two prescaler giving carrier and length-counter tick enables
`timescale 1ns/1ps
module rpu_divider
    import rpu_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    rpu_tick_if.div   tk
);
    logic [RPU_DIV_W-1:0] prescale;

    // tick when the low code bits of the prescaler all reach one
    function automatic logic tick_of(input logic [3:0] sel, input logic [RPU_DIV_W-1:0] cnt);
        logic [RPU_DIV_W-1:0] mask;
        mask = (RPU_DIV_ONE << sel) - RPU_DIV_ONE;
        tick_of = (sel != RPU_SEL_RESVD) && ((cnt & mask) == mask);
    endfunction : tick_of

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prescale <= '0;
        end else if (!tk.run) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + RPU_DIV_ONE;
        end
    end

    assign tk.cg_tick = tk.run && tick_of(tk.cg_sel, prescale);
    assign tk.lc_tick = tk.run && tick_of(tk.lc_sel, prescale);

    AST_LC_DIV1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (tk.run && tk.lc_sel == RPU_SEL_RESET) |-> tk.lc_tick)
        else $error("length tick missing at divide by one");
    AST_CG_RESVD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (tk.cg_sel == RPU_SEL_RESVD) |-> !tk.cg_tick)
        else $error("carrier tick on reserved code");
endmodule : rpu_divider

// ==== rpu_remote_pulse_unit.sv ====
// top: remote pulse unit with register port, carrier, length counter, edge detect
// Operation
// - written length counts down per length tick
// - receive mode shows received level in data bit
// - underflow raised in both directions
// - three causes merged onto one request
// - underflow flag set on reaching zero
// - rise flag set on low-to-high input
// - fall flag set on high-to-low input
// - flag forwarded only when enabled, enables reset low
// - writing one clears a cause flag
// - four registers at 0x5340 to 0x5346
// - sixteen-bit registers, reserved bits read zero
// - carrier clock divide by two to code
// - length clock divide, same encoding
// - bit1 direction receive, bit0 enable
// - input change accepted after two equal samples
// - counter holds zero until reloaded
// - carrier high h+1, low l+1 ticks
// - transmit pin is data gated by carrier
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module rpu_remote_pulse_unit
    import rpu_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        receive_input_pin_i,
    output logic             transmit_output_pin_o,
    output logic             irq_o
);
    logic [3:0]      carrier_clock_select;
    logic [3:0]      length_clock_select;
    logic            direction_select;
    logic            block_enable;
    logic [5:0]      carrier_high_length;
    logic [5:0]      carrier_low_length;
    logic [7:0]      pulse_length_count;
    logic            transfer_level_bit;
    logic [2:0]      cause_flag;
    logic [2:0]      cause_enable;
    logic [2:0]      pin_sync;
    logic            pin_seen;
    logic            samp_a;
    logic            samp_b;
    logic            rx_level;
    logic [5:0]      carr_cnt;
    rpu_carr_state_t carr_state;
    logic            carrier;
    logic            wr_cfg;
    logic            wr_car;
    logic            wr_len;
    logic            wr_int;
    logic            rx_mode;
    logic            rise_ev;
    logic            fall_ev;
    logic            uf_ev;
    logic [2:0]      set_ev;
    logic [2:0]      clr_ev;
    logic [15:0]     next_rdata;
    logic            cg_tick;
    logic            lc_tick;

    rpu_tick_if tk ();
    assign tk.run    = block_enable;
    assign tk.cg_sel = carrier_clock_select;
    assign tk.lc_sel = length_clock_select;
    assign cg_tick   = tk.cg_tick;
    assign lc_tick   = tk.lc_tick;

    rpu_divider u_div (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .tk      (tk)
    );

    // register decode
    assign wr_cfg  = wr_i && (addr_i == RPU_OFS_CONFIG);
    assign wr_car  = wr_i && (addr_i == RPU_OFS_CARRIER);
    assign wr_len  = wr_i && (addr_i == RPU_OFS_LENGTH);
    assign wr_int  = wr_i && (addr_i == RPU_OFS_INT);
    assign rx_mode = block_enable && direction_select;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carrier_clock_select <= RPU_SEL_RESET;
            length_clock_select  <= RPU_SEL_RESET;
            direction_select     <= 1'b0;
            block_enable         <= 1'b0;
        end else if (wr_cfg) begin
            carrier_clock_select <= wdata_i[RPU_CGSEL_MSB:RPU_CGSEL_LSB];
            length_clock_select  <= wdata_i[RPU_LCSEL_MSB:RPU_LCSEL_LSB];
            direction_select     <= wdata_i[RPU_DIR_BIT];
            block_enable         <= wdata_i[RPU_EN_BIT];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carrier_high_length <= RPU_CARR_RESET;
            carrier_low_length  <= RPU_CARR_RESET;
        end else if (wr_car) begin
            carrier_high_length <= wdata_i[RPU_CH_MSB:RPU_CH_LSB];
            carrier_low_length  <= wdata_i[RPU_CL_MSB:RPU_CL_LSB];
        end
    end

    // length counter: load on write, count down on tick, hold at zero
    assign uf_ev = block_enable && lc_tick && !wr_len && (pulse_length_count == RPU_LEN_ONE);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulse_length_count <= RPU_LEN_RESET;
        end else if (wr_len) begin
            pulse_length_count <= wdata_i[RPU_LEN_MSB:RPU_LEN_LSB];
        end else if (block_enable && lc_tick && pulse_length_count != RPU_LEN_ZERO) begin
            pulse_length_count <= pulse_length_count - RPU_LEN_ONE;
        end
    end

    // data bit: software value in transmit, received level in receive
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transfer_level_bit <= 1'b0;
        end else if (rx_mode) begin
            transfer_level_bit <= rx_level;
        end else if (wr_len) begin
            transfer_level_bit <= wdata_i[RPU_DT_BIT];
        end
    end

    // pin synchroniser
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sync <= 3'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], receive_input_pin_i};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_seen <= 1'b0;
        end else if (pin_sync[2] == pin_sync[1]) begin
            pin_seen <= pin_sync[2];
        end
    end

    // carrier-rate sampling; level accepted after two equal samples
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            samp_a <= 1'b0;
            samp_b <= 1'b0;
        end else if (rx_mode && cg_tick) begin
            samp_a <= pin_seen;
            samp_b <= samp_a;
        end
    end

    assign rise_ev = rx_mode && (samp_a == samp_b) && samp_a && !rx_level;
    assign fall_ev = rx_mode && (samp_a == samp_b) && !samp_a && rx_level;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_level <= 1'b0;
        end else if (!rx_mode) begin
            rx_level <= 1'b0;
        end else if (rise_ev || fall_ev) begin
            rx_level <= samp_a;
        end
    end

    // carrier generator
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carr_state <= RPU_CARR_HIGH;
            carr_cnt   <= RPU_CARR_RESET;
        end else if (!block_enable) begin
            carr_state <= RPU_CARR_HIGH;
            carr_cnt   <= RPU_CARR_RESET;
        end else if (cg_tick) begin
            case (carr_state)
                RPU_CARR_HIGH: begin
                    if (carr_cnt >= carrier_high_length) begin
                        carr_state <= RPU_CARR_LOW;
                        carr_cnt   <= RPU_CARR_RESET;
                    end else begin
                        carr_cnt <= carr_cnt + RPU_CNT_ONE;
                    end
                end
                RPU_CARR_LOW: begin
                    if (carr_cnt >= carrier_low_length) begin
                        carr_state <= RPU_CARR_HIGH;
                        carr_cnt   <= RPU_CARR_RESET;
                    end else begin
                        carr_cnt <= carr_cnt + RPU_CNT_ONE;
                    end
                end
                default: begin
                    carr_state <= RPU_CARR_HIGH;
                    carr_cnt   <= RPU_CARR_RESET;
                end
            endcase
        end
    end

    assign carrier = (carr_state == RPU_CARR_HIGH);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_output_pin_o <= 1'b0;
        end else begin
            transmit_output_pin_o <= block_enable && !direction_select && transfer_level_bit && carrier;
        end
    end

    // cause flags: set wins over write-one clear
    assign set_ev = {fall_ev, rise_ev, uf_ev};
    assign clr_ev = wr_int ? wdata_i[RPU_FLAG_LSB +: 3] : RPU_CAUSE_NONE;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cause_flag <= RPU_CAUSE_NONE;
        end else begin
            cause_flag <= set_ev | (cause_flag & ~clr_ev);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cause_enable <= RPU_CAUSE_NONE;
        end else if (wr_int) begin
            cause_enable <= wdata_i[RPU_IE_LSB +: 3];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(cause_flag & cause_enable);
        end
    end

    // read mux, reserved bits zero
    always_comb begin
        next_rdata = RPU_RD_ZERO;
        case (addr_i)
            RPU_OFS_CONFIG: begin
                next_rdata[RPU_CGSEL_MSB:RPU_CGSEL_LSB] = carrier_clock_select;
                next_rdata[RPU_LCSEL_MSB:RPU_LCSEL_LSB] = length_clock_select;
                next_rdata[RPU_DIR_BIT]                 = direction_select;
                next_rdata[RPU_EN_BIT]                  = block_enable;
            end
            RPU_OFS_CARRIER: begin
                next_rdata[RPU_CL_MSB:RPU_CL_LSB] = carrier_low_length;
                next_rdata[RPU_CH_MSB:RPU_CH_LSB] = carrier_high_length;
            end
            RPU_OFS_LENGTH: begin
                next_rdata[RPU_LEN_MSB:RPU_LEN_LSB] = pulse_length_count;
                next_rdata[RPU_DT_BIT]              = transfer_level_bit;
            end
            RPU_OFS_INT: begin
                next_rdata[RPU_FLAG_LSB +: 3] = cause_flag;
                next_rdata[RPU_IE_LSB +: 3]   = cause_enable;
            end
            default: begin
                next_rdata = RPU_RD_ZERO;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= RPU_RD_ZERO;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= RPU_RD_ZERO;
        end
    end

    AST_COUNT_DOWN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (block_enable && lc_tick && !wr_len && pulse_length_count != RPU_LEN_ZERO)
        |=> pulse_length_count == $past(pulse_length_count) - RPU_LEN_ONE)
        else $error("length counter did not step down");
    AST_HOLD_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (pulse_length_count == RPU_LEN_ZERO && !wr_len) |=> pulse_length_count == RPU_LEN_ZERO)
        else $error("length counter left zero without load");
    AST_UF_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        uf_ev |=> cause_flag[RPU_UF] && pulse_length_count == RPU_LEN_ZERO)
        else $error("underflow flag not set at zero");
    AST_RX_LEVEL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rx_mode && $past(rx_mode)) |-> transfer_level_bit == $past(rx_level))
        else $error("data bit does not follow received level");
    AST_RISE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rise_ev |=> cause_flag[RPU_RE] && rx_level)
        else $error("rise flag not set");
    AST_FALL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        fall_ev |=> cause_flag[RPU_FE] && !rx_level)
        else $error("fall flag not set");
    AST_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_int && wdata_i[RPU_FLAG_LSB + RPU_UF] && !uf_ev) |=> !cause_flag[RPU_UF])
        else $error("underflow flag not cleared by write one");
    AST_IRQ: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        irq_o == $past(|(cause_flag & cause_enable)))
        else $error("request does not match flags and enables");
    AST_TX_PIN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        transmit_output_pin_o |-> $past(transfer_level_bit && !direction_select && carrier))
        else $error("transmit pin high without data and carrier");
    AST_LEN_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_len |=> pulse_length_count == $past(wdata_i[RPU_LEN_MSB:RPU_LEN_LSB]))
        else $error("length counter not loaded by write");
    AST_UF_ONLY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(cause_flag[RPU_UF]) |-> $past(uf_ev))
        else $error("underflow flag set without reaching zero");
    AST_CLEAR_RISE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_int && wdata_i[RPU_FLAG_LSB + RPU_RE] && !rise_ev) |=> !cause_flag[RPU_RE])
        else $error("rise flag not cleared by write one");
    AST_CLEAR_FALL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_int && wdata_i[RPU_FLAG_LSB + RPU_FE] && !fall_ev) |=> !cause_flag[RPU_FE])
        else $error("fall flag not cleared by write one");
    AST_TX_FOLLOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (block_enable && !direction_select && transfer_level_bit && carrier) |=> transmit_output_pin_o)
        else $error("transmit pin low with data and carrier high");
    AST_TX_QUIET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!block_enable || direction_select) |=> !transmit_output_pin_o)
        else $error("transmit pin active while halted or receiving");
    AST_CARR_TO_LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (block_enable && cg_tick && carr_state == RPU_CARR_HIGH && carr_cnt >= carrier_high_length)
        |=> carr_state == RPU_CARR_LOW)
        else $error("carrier high phase too long");
    AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !rd_i |=> rdata_o == RPU_RD_ZERO)
        else $error("read data not zero outside read cycle");
endmodule : rpu_remote_pulse_unit

// ==== rpu_ir_partner.sv ====
// partner: ir receiver front end and transmit diode run-length monitor
`timescale 1ns/1ps
module rpu_ir_partner (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       light_i,
    input  wire logic       tx_pin_i,
    output logic            rx_pin_o,
    output logic [7:0]      hi_len_o,
    output logic [7:0]      lo_len_o
);
    logic       last;
    logic [7:0] run;
    // push-pull receiver output, never released
    assign rx_pin_o = light_i;
    // length of the last finished high and low runs on the diode
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last     <= 1'b0;
            run      <= 8'h01;
            hi_len_o <= 8'h00;
            lo_len_o <= 8'h00;
        end else if (tx_pin_i == last) begin
            run <= run + 8'h01;
        end else begin
            if (last) hi_len_o <= run;
            else lo_len_o <= run;
            run  <= 8'h01;
            last <= tx_pin_i;
        end
    end
endmodule : rpu_ir_partner

// ==== rpu_tb.sv ====
// testbench: register, length counter, carrier and receive scenarios
`timescale 1ns/1ps
module testbench;
    import rpu_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic        rx_pin;
    logic        tx_pin;
    logic        irq_o;
    logic        light = 1'b0;
    logic [7:0]  hi_len;
    logic [7:0]  lo_len;
    logic [15:0] v;
    int          err_total = 0;
    int          tests_run = 0;
    bit          hit;

    always #20 mclk_i = ~mclk_i;

    rpu_remote_pulse_unit u_rpu_remote_pulse_unit (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .receive_input_pin_i(rx_pin),
        .transmit_output_pin_o(tx_pin), .irq_o(irq_o));
    rpu_ir_partner u_rpu_ir_partner (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .light_i(light), .tx_pin_i(tx_pin),
        .rx_pin_o(rx_pin), .hi_len_o(hi_len), .lo_len_o(lo_len));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        d = rdata_o;
        @(posedge mclk_i);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : idle
    task automatic wait_irq(input int n, output bit h);
        h = 1'b0;
        for (int i = 0; i < n && !h; i++) begin
            @(posedge mclk_i);
            h = (irq_o === 1'b1);
        end
    endtask : wait_irq

    task automatic t_regs();
        logic [15:0] ofs [4];
        ofs = '{RPU_OFS_CONFIG, RPU_OFS_CARRIER, RPU_OFS_LENGTH, RPU_OFS_INT};
        foreach (ofs[i]) begin
            rd(ofs[i], v);
            check("reset value", v, 16'h0000);
        end
        check("irq after reset", irq_o, 16'h0000);
        wr(16'h5348, 16'hFFFF);
        rd(16'h5348, v);
        check("unmapped", v, 16'h0000);
        wr(RPU_OFS_CARRIER, 16'h3F3F);
        rd(RPU_OFS_CARRIER, v);
        check("carrier reserved", v, 16'h3F3F);
        @(negedge mclk_i);
        check("read data idle", rdata_o, 16'h0000);
        wr(RPU_OFS_CONFIG, 16'hEE02);
        rd(RPU_OFS_CONFIG, v);
        check("config reserved", v, 16'hEE02);
        wr(RPU_OFS_INT, 16'h0707);
        rd(RPU_OFS_INT, v);
        check("int reserved", v, 16'h0007);
        wr(RPU_OFS_INT, 16'h0000);
        wr(RPU_OFS_CONFIG, 16'h0000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_count();
        wr(RPU_OFS_INT, 16'h0001);
        wr(RPU_OFS_CONFIG, 16'h0200);
        wr(RPU_OFS_CONFIG, 16'h0201);
        wr(RPU_OFS_LENGTH, 16'h0500);
        // five ticks of pclk/4 take 17 to 20 cycles
        idle(12);
        check("irq before underflow", irq_o, 16'h0000);
        wait_irq(16, hit);
        check("underflow irq", hit, 16'h0001);
        rd(RPU_OFS_INT, v);
        check("underflow flag", v, 16'h0101);
        idle(20);
        rd(RPU_OFS_LENGTH, v);
        check("count holds zero", v, 16'h0000);
        check("irq stays", irq_o, 16'h0001);
        wr(RPU_OFS_INT, 16'h0101);
        rd(RPU_OFS_INT, v);
        check("flag cleared", v, 16'h0001);
        check("irq cleared", irq_o, 16'h0000);
        wr(RPU_OFS_INT, 16'h0000);
        wr(RPU_OFS_LENGTH, 16'h0100);
        idle(10);
        rd(RPU_OFS_INT, v);
        check("masked flag", v, 16'h0100);
        check("masked irq", irq_o, 16'h0000);
        wr(RPU_OFS_INT, 16'h0100);
        wr(RPU_OFS_CONFIG, 16'h0200);
        $display("test count done");
    endtask : t_count

    task automatic t_carrier();
        wr(RPU_OFS_CARRIER, 16'h0102);
        wr(RPU_OFS_LENGTH, 16'h0001);
        for (int c = 0; c < 2; c++) begin
            wr(RPU_OFS_CONFIG, 16'h0000);
            wr(RPU_OFS_CONFIG, 16'(c) << RPU_CGSEL_LSB);
            wr(RPU_OFS_CONFIG, (16'(c) << RPU_CGSEL_LSB) | 16'h0001);
            idle(40);
            check("carrier high run", hi_len, 16'(3 << c));
            check("carrier low run", lo_len, 16'(2 << c));
        end
        wr(RPU_OFS_LENGTH, 16'h0000);
        idle(3);
        hit = 1'b0;
        repeat (20) begin
            @(posedge mclk_i);
            hit |= (tx_pin !== 1'b0);
        end
        check("low data silent", hit, 16'h0000);
        wr(RPU_OFS_CONFIG, 16'h1000);
        $display("test carrier done");
    endtask : t_carrier

    task automatic t_receive();
        int c;
        wr(RPU_OFS_INT, 16'h0006);
        wr(RPU_OFS_CONFIG, 16'h0002);
        wr(RPU_OFS_CONFIG, 16'h0003);
        @(posedge mclk_i);
        light <= 1'b1;
        wait_irq(30, hit);
        check("rise irq", hit, 16'h0001);
        rd(RPU_OFS_INT, v);
        check("rise flag", v, 16'h0206);
        wr(RPU_OFS_INT, 16'h0206);
        wr(RPU_OFS_LENGTH, 16'hFF00);
        c = 0;
        fork
            begin
                idle(50);
                light <= 1'b0;
            end
            begin
                wait_irq(90, hit);
                c = 1;
            end
        join
        rd(RPU_OFS_LENGTH, v);
        // elapsed cycles from the reload write to the read strobe is 50 plus the detection delay
        check("fall irq", hit, 16'h0001);
        check("pulse length", 16'((8'hFF - v[15:8]) inside {[8'd52 : 8'd66]}), 16'h0001);
        check("rx data low", v[0], 16'h0000);
        rd(RPU_OFS_INT, v);
        check("fall flag", v, 16'h0406);
        wr(RPU_OFS_INT, 16'h0407);
        wr(RPU_OFS_LENGTH, 16'hFF00);
        wait_irq(270, hit);
        check("rx underflow irq", hit, 16'h0001);
        rd(RPU_OFS_INT, v);
        check("rx underflow", v, 16'h0107);
        wr(RPU_OFS_INT, 16'h0106);
        wr(RPU_OFS_CONFIG, 16'h0002);
        wr(RPU_OFS_CONFIG, 16'h3003);
        @(posedge mclk_i);
        light <= 1'b1;
        idle(3);
        light <= 1'b0;
        idle(60);
        rd(RPU_OFS_INT, v);
        check("glitch ignored", v, 16'h0006);
        light <= 1'b1;
        wait_irq(60, hit);
        check("slow rise", hit, 16'h0001);
        rd(RPU_OFS_LENGTH, v);
        check("rx data high", v[0], 16'h0001);
        wr(RPU_OFS_CONFIG, 16'h3002);
        $display("test receive done");
    endtask : t_receive

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    initial begin
        idle(3);
        rst_n_i <= 1'b1;
        t_regs();
        t_count();
        t_carrier();
        t_receive();
        test_done();
    end
    initial begin
        #(40 * 5000);
        err_total++;
        test_done();
    end
endmodule : testbench
